// ===== epc_map.vh
// Register offsets, field positions, encodings and reset values for the enhanced PWM unit.
`ifndef EPC_MAP_VH
`define EPC_MAP_VH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define EPC_OFF_CTRL1   8'h00
`define EPC_OFF_CTRL2   8'h04
`define EPC_OFF_CTRL3   8'h08
`define EPC_OFF_CMP1    8'h0C
`define EPC_OFF_CMP2    8'h10
`define EPC_OFF_CMP3    8'h14
`define EPC_OFF_TIMCTL  8'h18
`define EPC_OFF_PERA    8'h1C
`define EPC_OFF_PERB    8'h20
`define EPC_OFF_DEAD    8'h24
`define EPC_OFF_TIMERS  8'h28
`define EPC_OFF_STAT    8'h2C
`define EPC_OFF_IRQEN   8'h30
`define EPC_OFF_IRQCLR  8'h34
`define EPC_OFF_OUTS    8'h38
`define EPC_OFF_SHADOW  8'h3C

// -----------------------------------------------------------------
// Timer three control bits
// -----------------------------------------------------------------
`define EPC_TC_T1ON     0
`define EPC_TC_T3ON     1
`define EPC_TC_CMPSEL   2
`define EPC_TC_PWMSEL   3
`define EPC_TC_TBAON    4
`define EPC_TC_TBBON    5
`define EPC_TC_ADON     6

// -----------------------------------------------------------------
// Unit mode field and output configuration encodings
// -----------------------------------------------------------------
`define EPC_MODE_TOGGLE 4'h2
`define EPC_MODE_CSET   4'h8
`define EPC_MODE_CCLR   4'h9
`define EPC_MODE_SWI    4'hA
`define EPC_MODE_SPEV   4'hB
`define EPC_MODE_PWM    2'h3
`define EPC_CFG_SINGLE  2'h0
`define EPC_CFG_FWD     2'h1
`define EPC_CFG_HALF    2'h2
`define EPC_CFG_REV     2'h3

// -----------------------------------------------------------------
// Status bits and reset values
// -----------------------------------------------------------------
`define EPC_ST_MATCH1   0
`define EPC_ST_T1OVF    3
`define EPC_ST_T3OVF    4
`define EPC_ST_ADC      5
`define EPC_ST_W        6
`define EPC_RST_CTRL    8'h00
`define EPC_RST_CMP     16'h0000
`define EPC_RST_PER     8'hFF
`define EPC_RST_TIMCTL  7'h00

`endif

// ===== epc_top.v
// Enhanced compare / PWM unit: special event trigger, multi-output PWM and APB registers.
//
// Behaviour
// [RULE1] Mode 1011 match pulses a trigger, units one/two
// [RULE2] Trigger resets the selected sixteen-bit timer
// [RULE3] Unit two trigger starts conversion when enabled
// [RULE4] Unit three trigger mode acts as 1010
// [RULE5] Trigger resets never set timer overflow flags
// [RULE6] Other compare modes behave as standard compare
// [RULE7] Single output equals standard PWM
// [RULE8] Four outputs A-D with selectable polarity
// [RULE9] Config from bits 7:6, mode from 3:0
// [RULE10] Config selects one, two or four pins
// [RULE11] Quad unit three D overrides unit four pin
// [RULE12] Timebase select bit in timer three control
// [RULE13] Controls load only at period boundary
// [RULE14] Dead-band loads at duty or period boundary
// [RULE15] Output starts after first timebase reset
// [RULE16] Software sets port direction bits itself
// [RULE17] Period match clears timer, sets output, copies duty
// [RULE18] Duty is eight high plus two low bits
// [RULE19] Trigger lasts one cycle per match
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "epc_map.vh"

module epc_top #(
  parameter TMR_W = 16,
  parameter TB_W  = 8
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Standard unit outputs to be overridden
  input  wire        std4Out,
  input  wire        std5Out,
  // Pins and events
  output reg  [11:0] pwmOut,
  output reg  [11:0] pinUsed,
  output reg         pin4Out,
  output reg         pin5Out,
  output reg         adcStart,
  output reg         irq
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  reg [7:0]       ctrl_r   [0:2];
  reg [15:0]      cmp_r    [0:2];
  reg [1:0]       cfgSh_r  [0:2];
  reg [1:0]       polSh_r  [0:2];
  reg [9:0]       dutySh_r [0:2];
  reg [2:0]       pwmOn_r;
  reg [2:0]       lvl_r;
  reg [2:0]       cmpOut_r;
  reg [2:0]       matchPrev_r;
  reg [TB_W-1:0]  tbCnt_r  [0:1];
  reg [1:0]       tbQ_r    [0:1];
  reg [TB_W-1:0]  per_r    [0:1];
  reg [TMR_W-1:0] t1_r;
  reg [TMR_W-1:0] t3_r;
  reg [6:0]       timCtl_r;
  reg [6:0]       deadReg_r;
  reg [6:0]       deadSh_r;
  reg             deadPend_r;
  reg [5:0]       stat_r;
  reg [5:0]       irqEn_r;

  integer         u;
  integer         t;
  integer         tTmr;
  integer         uUnit;
  integer         uPin;
  integer         uBus;

  // ---------------------------------------------------------------
  // Output mapping
  // ---------------------------------------------------------------
  // Returns {D,C,B,A} active levels before polarity.
  function [3:0] epc_route;
    input [1:0] cfg;
    input       lvl;
    begin
      case (cfg)
        `EPC_CFG_SINGLE: epc_route = {3'b000, lvl};
        `EPC_CFG_HALF:   epc_route = {2'b00, ~lvl, lvl};
        `EPC_CFG_FWD:    epc_route = {lvl, 2'b00, 1'b1};
        `EPC_CFG_REV:    epc_route = {1'b0, 1'b1, lvl, 1'b0};
        default:         epc_route = 4'b0000;
      endcase
    end
  endfunction

  // Pins that the configuration claims.
  function [3:0] epc_used;
    input [1:0] cfg;
    begin
      if (cfg[0])
        epc_used = 4'b1111;
      else if (cfg[1])
        epc_used = 4'b0011;
      else
        epc_used = 4'b0001;
    end
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire             cmpSel  = timCtl_r[`EPC_TC_CMPSEL];
  wire             pwmSel  = timCtl_r[`EPC_TC_PWMSEL];
  wire [TMR_W-1:0] cmpTmr  = cmpSel ? t3_r : t1_r;
  wire [1:0]       tbOn    = {timCtl_r[`EPC_TC_TBBON], timCtl_r[`EPC_TC_TBAON]};
  wire             wrEn    = psel & penable & pready & pwrite;

  reg  [1:0]  tbBnd;
  reg  [2:0]  isPwm;
  reg  [2:0]  matchEv;
  reg  [2:0]  setEv;
  reg  [2:0]  swEv;
  reg  [2:0]  dutyHit;
  reg  [9:0]  cnt10;
  reg  [9:0]  dutyNew  [0:2];
  reg  [3:0]  mode;
  reg  [3:0]  pinLvl   [0:2];
  reg         setT1;
  reg         setT3;

  always @*
  begin
    for (t = 0; t < 2; t = t + 1)
      tbBnd[t] = tbOn[t] && (tbQ_r[t] == 2'b11) && (tbCnt_r[t] == per_r[t]);
    cnt10 = {tbCnt_r[pwmSel][7:0], tbQ_r[pwmSel]};
    for (u = 0; u < 3; u = u + 1)
    begin
      mode       = ctrl_r[u][3:0]; // see [RULE9]
      isPwm[u]   = (mode[3:2] == `EPC_MODE_PWM);
      matchEv[u] = (cmp_r[u] == cmpTmr) && !isPwm[u] && (mode[3] || mode == `EPC_MODE_TOGGLE)
                   && !matchPrev_r[u]; // see [RULE19]
      setEv[u]   = matchEv[u] && (mode == `EPC_MODE_SPEV) && (u < 2); // see [RULE1] [RULE4]
      swEv[u]    = matchEv[u]; // see [RULE6]
      dutyNew[u] = {cmp_r[u][7:0], ctrl_r[u][5:4]}; // see [RULE18]
      dutyHit[u] = pwmOn_r[u] && (cnt10 + 10'h001 == dutySh_r[u]); // see [RULE17]
      pinLvl[u]  = epc_route(cfgSh_r[u], lvl_r[u])
                   ^ {polSh_r[u][0], polSh_r[u][1], polSh_r[u][0], polSh_r[u][1]}; // see [RULE8]
    end
    setT1 = (|setEv[1:0]) && !cmpSel; // see [RULE2]
    setT3 = (|setEv[1:0]) && cmpSel; // see [RULE2]
  end

  // ---------------------------------------------------------------
  // Timers
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      t1_r <= {TMR_W{1'b0}};
      t3_r <= {TMR_W{1'b0}};
      for (tTmr = 0; tTmr < 2; tTmr = tTmr + 1)
      begin
        tbCnt_r[tTmr] <= {TB_W{1'b0}};
        tbQ_r[tTmr]   <= 2'b00;
      end
    end
    else
    begin
      if (setT1)
        t1_r <= {TMR_W{1'b0}};
      else if (timCtl_r[`EPC_TC_T1ON])
        t1_r <= t1_r + 1'b1;
      if (setT3)
        t3_r <= {TMR_W{1'b0}};
      else if (timCtl_r[`EPC_TC_T3ON])
        t3_r <= t3_r + 1'b1;
      for (tTmr = 0; tTmr < 2; tTmr = tTmr + 1)
        if (tbOn[tTmr])
        begin
          tbQ_r[tTmr] <= tbQ_r[tTmr] + 2'b01;
          if (tbQ_r[tTmr] == 2'b11)
            tbCnt_r[tTmr] <= tbBnd[tTmr] ? {TB_W{1'b0}} : tbCnt_r[tTmr] + 1'b1; // see [RULE17]
        end
    end
  end

  // ---------------------------------------------------------------
  // Compare and PWM units
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      pwmOn_r     <= 3'b000;
      lvl_r       <= 3'b000;
      cmpOut_r    <= 3'b000;
      matchPrev_r <= 3'b000;
      for (uUnit = 0; uUnit < 3; uUnit = uUnit + 1)
      begin
        cfgSh_r[uUnit]  <= 2'b00;
        polSh_r[uUnit]  <= 2'b00;
        dutySh_r[uUnit] <= 10'h000;
      end
    end
    else
    begin
      for (uUnit = 0; uUnit < 3; uUnit = uUnit + 1)
      begin
        matchPrev_r[uUnit] <= (cmp_r[uUnit] == cmpTmr) && !isPwm[uUnit]; // see [RULE19]
        if (matchEv[uUnit])
          case (ctrl_r[uUnit][3:0])
            `EPC_MODE_CSET:   cmpOut_r[uUnit] <= 1'b1;
            `EPC_MODE_CCLR:   cmpOut_r[uUnit] <= 1'b0;
            `EPC_MODE_TOGGLE: cmpOut_r[uUnit] <= ~cmpOut_r[uUnit];
            default:          cmpOut_r[uUnit] <= cmpOut_r[uUnit];
          endcase // see [RULE6]
        if (!isPwm[uUnit])
        begin
          pwmOn_r[uUnit] <= 1'b0;
          lvl_r[uUnit]   <= 1'b0;
        end
        else if (tbBnd[pwmSel])
        begin
          pwmOn_r[uUnit]  <= 1'b1; // see [RULE15]
          cfgSh_r[uUnit]  <= ctrl_r[uUnit][7:6]; // see [RULE13] [RULE12]
          polSh_r[uUnit]  <= ctrl_r[uUnit][1:0]; // see [RULE13]
          dutySh_r[uUnit] <= dutyNew[uUnit]; // see [RULE17]
          lvl_r[uUnit]    <= (dutyNew[uUnit] != 10'h000); // see [RULE17] [RULE7]
        end
        else if (dutyHit[uUnit])
          lvl_r[uUnit] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins, trigger and dead-band shadow
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      pwmOut     <= 12'h000;
      pinUsed    <= 12'h000;
      pin4Out    <= 1'b0;
      pin5Out    <= 1'b0;
      adcStart   <= 1'b0;
      deadSh_r   <= 7'h00;
      deadPend_r <= 1'b0;
    end
    else
    begin
      for (uPin = 0; uPin < 3; uPin = uPin + 1)
        if (isPwm[uPin] && pwmOn_r[uPin])
        begin
          pwmOut[4*uPin +: 4]  <= pinLvl[uPin];
          pinUsed[4*uPin +: 4] <= epc_used(cfgSh_r[uPin]); // see [RULE10]
        end
        else
        begin
          pwmOut[4*uPin +: 4]  <= {3'b000, cmpOut_r[uPin]};
          pinUsed[4*uPin +: 4] <= 4'b0001;
        end
      pin4Out  <= (pwmOn_r[2] && cfgSh_r[2][0]) ? pinLvl[2][3] : std4Out; // see [RULE11]
      pin5Out  <= (pwmOn_r[0] && cfgSh_r[0][0]) ? pinLvl[0][3] : std5Out;
      adcStart <= setEv[1] && timCtl_r[`EPC_TC_ADON]; // see [RULE3]
      if (deadPend_r && (tbBnd[pwmSel] || dutyHit[0]))
        deadSh_r <= deadReg_r; // see [RULE14]
      if (wrEn && paddr == `EPC_OFF_DEAD)
        deadPend_r <= 1'b1;
      else if (tbBnd[pwmSel] || dutyHit[0])
        deadPend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------
  wire [5:0] evVec = {adcStart,
                      timCtl_r[`EPC_TC_T3ON] && (&t3_r) && !setT3,
                      timCtl_r[`EPC_TC_T1ON] && (&t1_r) && !setT1,
                      swEv}; // see [RULE5]
  wire [5:0] clrVec = (wrEn && paddr == `EPC_OFF_IRQCLR) ? pwdata[5:0] : 6'h00;

  always @(posedge clk)
  begin
    if (reset)
    begin
      stat_r <= 6'h00;
      irq    <= 1'b0;
    end
    else
    begin
      stat_r <= (stat_r & ~clrVec) | evVec;
      irq    <= |(stat_r & irqEn_r);
    end
  end

  // ---------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------
  reg [31:0] rdMux;
  reg        hit;

  always @*
  begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      `EPC_OFF_CTRL1:  rdMux = {24'h00_0000, ctrl_r[0]};
      `EPC_OFF_CTRL2:  rdMux = {24'h00_0000, ctrl_r[1]};
      `EPC_OFF_CTRL3:  rdMux = {24'h00_0000, ctrl_r[2]};
      `EPC_OFF_CMP1:   rdMux = {16'h0000, cmp_r[0]};
      `EPC_OFF_CMP2:   rdMux = {16'h0000, cmp_r[1]};
      `EPC_OFF_CMP3:   rdMux = {16'h0000, cmp_r[2]};
      `EPC_OFF_TIMCTL: rdMux = {25'h000_0000, timCtl_r};
      `EPC_OFF_PERA:   rdMux = {24'h00_0000, per_r[0]};
      `EPC_OFF_PERB:   rdMux = {24'h00_0000, per_r[1]};
      `EPC_OFF_DEAD:   rdMux = {25'h000_0000, deadReg_r};
      `EPC_OFF_TIMERS: rdMux = {t3_r, t1_r};
      `EPC_OFF_STAT:   rdMux = {26'h000_0000, stat_r};
      `EPC_OFF_IRQEN:  rdMux = {26'h000_0000, irqEn_r};
      `EPC_OFF_IRQCLR: rdMux = 32'h0000_0000;
      `EPC_OFF_OUTS:   rdMux = {4'h0, pinUsed, 2'b00, pin5Out, pin4Out, pwmOut};
      `EPC_OFF_SHADOW: rdMux = {15'h0000, deadSh_r, dutySh_r[0]};
      default:         hit   = 1'b0;
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      timCtl_r  <= `EPC_RST_TIMCTL;
      deadReg_r <= 7'h00;
      irqEn_r   <= 6'h00;
      per_r[0]  <= `EPC_RST_PER;
      per_r[1]  <= `EPC_RST_PER;
      for (uBus = 0; uBus < 3; uBus = uBus + 1)
      begin
        ctrl_r[uBus] <= `EPC_RST_CTRL;
        cmp_r[uBus]  <= `EPC_RST_CMP;
      end
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable)
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      if (wrEn)
        case (paddr)
          `EPC_OFF_CTRL1:  ctrl_r[0] <= pwdata[7:0];
          `EPC_OFF_CTRL2:  ctrl_r[1] <= pwdata[7:0];
          `EPC_OFF_CTRL3:  ctrl_r[2] <= pwdata[7:0];
          `EPC_OFF_CMP1:   cmp_r[0]  <= pwdata[15:0];
          `EPC_OFF_CMP2:   cmp_r[1]  <= pwdata[15:0];
          `EPC_OFF_CMP3:   cmp_r[2]  <= pwdata[15:0];
          `EPC_OFF_TIMCTL: timCtl_r  <= pwdata[6:0];
          `EPC_OFF_PERA:   per_r[0]  <= pwdata[7:0];
          `EPC_OFF_PERB:   per_r[1]  <= pwdata[7:0];
          `EPC_OFF_DEAD:   deadReg_r <= pwdata[6:0];
          `EPC_OFF_IRQEN:  irqEn_r   <= pwdata[5:0];
          default:         irqEn_r   <= irqEn_r;
        endcase
    end
  end

endmodule

// ===== epc_props.sv
// Checker of the port behaviour of the enhanced compare / PWM unit.
`timescale 1ns/1ps
module epc_props #(
  parameter TMR_W = 16,
  parameter TB_W  = 8
) (
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // APB slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Standard unit outputs
  input wire        std4Out,
  input wire        std5Out,
  // Pins and events
  input wire [11:0] pwmOut,
  input wire [11:0] pinUsed,
  input wire        pin4Out,
  input wire        pin5Out,
  input wire        adcStart,
  input wire        irq
);
  // ---------------------------------------------------------------
  // Port properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  function automatic logic okUse(input logic [3:0] n);
    return n == 4'h0 || n == 4'h1 || n == 4'h3 || n == 4'hF;
  endfunction
  a_setup_gets_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_adc_single_pulse: assert property (adcStart |=> !adcStart)
    else $error("conversion start too long");
  a_pin4_follows_std: assert property (
    !pinUsed[11] && $past(!pinUsed[11]) && !$past(reset) |-> pin4Out == $past(std4Out))
    else $error("pin four not passed through");
  a_pin5_follows_std: assert property (
    !pinUsed[3] && $past(!pinUsed[3]) && !$past(reset) |-> pin5Out == $past(std5Out))
    else $error("pin five not passed through");
  a_pin_usage_legal: assert property (
    okUse(pinUsed[3:0]) && okUse(pinUsed[7:4]) && okUse(pinUsed[11:8]))
    else $error("illegal pin usage");
  a_reset_quiet: assert property (
    $past(reset) |-> pwmOut == 12'h000 && pinUsed == 12'h000 && !adcStart && !irq)
    else $error("outputs active after reset");
  c_adc: cover property (adcStart);
  c_err: cover property (pslverr);
  c_quad: cover property (pinUsed[11]);
endmodule

bind epc_top epc_props #(.TMR_W(TMR_W), .TB_W(TB_W)) i_epc_props (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .std4Out(std4Out), .std5Out(std5Out), .pwmOut(pwmOut),
  .pinUsed(pinUsed), .pin4Out(pin4Out), .pin5Out(pin5Out),
  .adcStart(adcStart), .irq(irq));

// ===== epc_load_model.sv
// Behavioural load on one PWM pin that counts the cycles it is driven high.
`timescale 1ns/1ps
module epc_load_model (
  // Clock
  input  wire        clk,
  // Port direction and pin
  input  wire        dirOut,
  input  wire        pin,
  // Measurement
  output reg  [15:0] highCnt
);
  initial highCnt = 16'h0000;
  always @(posedge clk)
    if (dirOut && pin)
      highCnt <= highCnt + 16'h0001;
endmodule

// ===== epc_top_tb_top.sv
// Self-checking bench of the enhanced compare / PWM unit.
`timescale 1ns/1ps
`include "epc_map.vh"
module epc_top_tb_top;
  reg         clk;
  reg         reset;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata;
  reg         std4Out;
  reg         dirOut;
  reg  [31:0] rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire [11:0] pwmOut;
  wire [11:0] pinUsed;
  wire        pin4Out;
  wire        pin5Out;
  wire        adcStart;
  wire        irq;
  wire [15:0] hiA;
  wire [15:0] hiD;
  integer     fails;
  integer     n_tests;

  epc_top i_epc_top (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .std4Out(std4Out), .std5Out(std4Out), .pwmOut(pwmOut),
    .pinUsed(pinUsed), .pin4Out(pin4Out), .pin5Out(pin5Out), .adcStart(adcStart),
    .irq(irq));
  epc_load_model i_loadA (.clk(clk), .dirOut(dirOut), .pin(pwmOut[0]), .highCnt(hiA));
  epc_load_model i_loadD (.clk(clk), .dirOut(dirOut), .pin(pin4Out), .highCnt(hiD));

  // ---------------------------------------------------------------
  // Clock and common tasks
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
    std4Out <= ~std4Out;
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
    end
  endtask
  task hang;
    begin
      fails = fails + 1;
      $display("wrong value at %0t: wait timed out", $time);
      finish_test;
    end
  endtask
  task doReset;
    begin
      reset <= 1'b1;
      tick(6);
      reset <= 1'b0;
      tick(1);
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20)
      begin
        k = k + 1;
        @(posedge clk);
      end
      if (pready !== 1'b1)
        hang;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task waitOn(input sel);
    integer k;
    begin
      k = 0;
      @(posedge clk);
      while ((sel ? adcStart : irq) !== 1'b1 && k < 300)
      begin
        k = k + 1;
        @(posedge clk);
      end
      if ((sel ? adcStart : irq) !== 1'b1)
        hang;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task scnRegs;
    begin
      apb(0, `EPC_OFF_PERA, 0);
      chk(rd, 32'hFF);
      apb(1, `EPC_OFF_CTRL3, 32'hFFFF_FFFF);
      apb(0, `EPC_OFF_CTRL3, 0);
      chk(rd, 32'hFF);
      apb(0, 8'h40, 0);
      chk({rd[30:0], err}, 32'h1);
    end
  endtask
  task scnTrig1(input [31:0] tc, input integer sh);
    begin
      doReset;
      apb(1, `EPC_OFF_CMP1, 32'h10);
      apb(1, `EPC_OFF_IRQEN, 32'h1);
      apb(1, `EPC_OFF_CTRL1, 32'hB);
      apb(1, `EPC_OFF_TIMCTL, tc);
      waitOn(0);
      apb(0, `EPC_OFF_TIMERS, 0);
      chk(((rd >> sh) & 32'hFFFF) <= 32'h10, 1);
      apb(0, `EPC_OFF_STAT, 0);
      chk(rd & 32'h19, 32'h1);
      apb(1, `EPC_OFF_CTRL1, 0);
      apb(1, `EPC_OFF_IRQCLR, 32'h1);
      apb(0, `EPC_OFF_STAT, 0);
      chk({rd[0], irq}, 0);
    end
  endtask
  task scnTrig2;
    integer n;
    begin
      doReset;
      apb(1, `EPC_OFF_CMP2, 32'h20);
      apb(1, `EPC_OFF_TIMCTL, 32'h41);
      apb(1, `EPC_OFF_CTRL2, 32'hB);
      waitOn(1);
      n = 0;
      repeat (66)
      begin
        @(posedge clk);
        if (adcStart === 1'b1)
          n = n + 1;
      end
      chk(n, 2);
      apb(0, `EPC_OFF_STAT, 0);
      chk(rd & 32'h3A, 32'h22);
      apb(1, `EPC_OFF_TIMCTL, 32'h1);
      apb(1, `EPC_OFF_IRQCLR, 32'h3F);
      n = 0;
      repeat (70)
      begin
        @(posedge clk);
        if (adcStart !== 1'b0)
          n = n + 1;
      end
      chk(n, 0);
      apb(0, `EPC_OFF_STAT, 0);
      chk(rd & 32'h3A, 32'h2);
    end
  endtask
  task scnTrig3;
    begin
      doReset;
      apb(1, `EPC_OFF_CMP3, 32'h10);
      apb(1, `EPC_OFF_CTRL3, 32'hB);
      apb(1, `EPC_OFF_TIMCTL, 32'h1);
      tick(40);
      apb(0, `EPC_OFF_TIMERS, 0);
      chk(rd[15:0] > 16'h10, 1);
      apb(0, `EPC_OFF_STAT, 0);
      chk({rd[2], irq}, 32'h2);
    end
  endtask
  task scnPwm(input [7:0] ctl, input [7:0] cmp);
    integer duty;
    integer exp;
    reg [15:0] h0;
    begin
      apb(1, `EPC_OFF_CMP1, cmp);
      apb(1, `EPC_OFF_CTRL1, ctl);
      tick(40);
      h0 = hiA;
      tick(64);
      duty = {cmp, ctl[5:4]};
      if (duty > 16)
        duty = 16;
      exp = ctl[1] ? 64 - 4 * duty : 4 * duty;
      chk(hiA - h0, exp);
    end
  endtask
  task scnQuad(input [7:0] ctl, input [3:0] pins, input [31:0] exp);
    reg [15:0] h0;
    begin
      apb(1, `EPC_OFF_CTRL3, ctl);
      tick(70);
      chk(pinUsed[11:8], pins);
      chk(pin5Out ^ std4Out, 1);
      h0 = hiD;
      tick(128);
      chk(hiD - h0, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    fails = 0;
    n_tests = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    std4Out = 1'b0;
    dirOut = 1'b0;
    doReset;
    dirOut <= 1'b1;
    scnRegs;
    scnTrig1(32'h1, 0);
    scnTrig1(32'h6, 16);
    scnTrig2;
    scnTrig3;
    doReset;
    apb(1, `EPC_OFF_PERA, 32'h3);
    apb(1, `EPC_OFF_TIMCTL, 32'h10);
    scnPwm(8'h1C, 8'h02);
    scnPwm(8'h0C, 8'h00);
    scnPwm(8'h0C, 8'h04);
    scnPwm(8'h3C, 8'hFF);
    scnPwm(8'h1E, 8'h02);
    apb(1, `EPC_OFF_DEAD, 32'h55);
    tick(20);
    apb(0, `EPC_OFF_SHADOW, 0);
    chk(rd, 32'h0001_5409);
    doReset;
    apb(1, `EPC_OFF_PERB, 32'h7);
    apb(1, `EPC_OFF_CMP3, 32'h2);
    apb(1, `EPC_OFF_TIMCTL, 32'h28);
    scnQuad(8'h1C, 4'h1, 64);
    scnQuad(8'h9C, 4'h3, 64);
    scnQuad(8'h5C, 4'hF, 36);
    finish_test;
  end
endmodule
